/* inc/rtc_pkg.sv */
// Purpose: shared constants and types of the nibble-bus clock controller pair
// Assumes: one 20 MHz clock for both ends
// Notes:   all timing counts derive from nanosecond figures and the clock rate
package rtc_pkg;
  // device register offsets on the nibble bus, bank independent
  localparam logic [3:0] REG_CTRL_ONE     = 4'hD;
  localparam logic [3:0] REG_CTRL_TWO     = 4'hE;
  // control register one fields
  localparam int         CR1_BANK_BIT     = 0;
  localparam int         CR1_RESTART_BIT  = 1;
  localparam int         CR1_ALARM_EN_BIT = 2;
  localparam int         CR1_CARRY_EN_BIT = 3;
  // control register two fields
  localparam int         CR2_OSC_BIT      = 0;
  localparam int         CR2_ALARM_BIT    = 1;
  localparam int         CR2_PERIODIC_BIT = 2;
  localparam int         CR2_BUSY_BIT     = 3;
  // reset values of the device control bits
  localparam logic       BANK_RST         = 1'b0;
  localparam logic       ALARM_EN_RST     = 1'b0;
  localparam logic       CARRY_EN_RST     = 1'b1;
  // timing
  localparam int         CLK_MHZ          = 20;
  localparam int         CE_SETUP_NS      = 500;
  localparam int         CE_HOLD_NS       = 500;
  localparam int         STROBE_NS        = 400;
  localparam logic [4:0] CE_SETUP_CNT     = 5'((CE_SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] CE_HOLD_CNT      = 5'((CE_HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] STROBE_CNT       = 5'((STROBE_NS * CLK_MHZ + 999) / 1000);
  // host apb register offsets
  localparam logic [11:0] HOST_CMD_OFS      = 12'h000;
  localparam logic [11:0] HOST_STAT_OFS     = 12'h004;
  localparam logic [11:0] HOST_IRQ_STAT_OFS = 12'h008;
  localparam logic [11:0] HOST_IRQ_MASK_OFS = 12'h00C;
  // host register fields
  localparam int         CMD_ADDR_LSB     = 0;
  localparam int         CMD_WRITE_BIT    = 4;
  localparam int         CMD_DATA_LSB     = 8;
  localparam int         STAT_BUSY_BIT    = 0;
  localparam int         STAT_RDATA_LSB   = 8;
  localparam int         IRQ_DONE_BIT     = 0;
  localparam int         IRQ_DEV_BIT      = 1;
  // host sequencer states
  typedef enum logic [1:0] {
    RTC_H_IDLE   = 2'b00,
    RTC_H_SETUP  = 2'b01,
    RTC_H_STROBE = 2'b10,
    RTC_H_HOLD   = 2'b11
  } rtc_host_state_t;
endpackage

/* inc/rtc_nib_if.sv */
// Purpose: nibble bus between host controller and clock device
// Assumes: data wire resolved here from the two output enables
// Notes:   undriven data reads as zero
`timescale 1ns/1ps
interface rtc_nib_if;
  logic       ce;
  logic       rd_n;
  logic       wr_n;
  logic [3:0] addr;
  logic [3:0] host_data_o;
  logic       host_data_oe;
  logic [3:0] dev_data_o;
  logic       dev_data_oe;
  logic [3:0] data;
  logic       interrupt_out_n;

  // wire level from whichever end drives
  assign data = host_data_oe ? host_data_o : (dev_data_oe ? dev_data_o : 4'h0);

  modport dev  (input ce, rd_n, wr_n, addr, data, output dev_data_o, dev_data_oe, interrupt_out_n);
  modport host (output ce, rd_n, wr_n, addr, host_data_o, host_data_oe, input data, interrupt_out_n);
endinterface

/* hdl/rtc_dev_ctrl.sv */
// Purpose: control and status registers of the nibble-bus clock device
// Assumes: counter chain, alarm compare and periodic generator sit outside
// Notes:   all bus pins pass a two-stage synchroniser before use
`timescale 1ns/1ps
module rtc_dev_ctrl (
  // clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // nibble bus
  rtc_nib_if.dev     bus,
  // counter chain side
  input  wire logic  osc_stopped,
  input  wire logic  alarm_match,
  input  wire logic  periodic_req,
  input  wire logic  periodic_level_mode,
  input  wire logic  sec_carry_in,
  input  wire logic  counter_busy,
  // control outputs
  output logic       bank_sel,
  output logic       alarm_irq_enable,
  output logic       seconds_carry_enable,
  output logic       timer_restart_reset,
  output logic       timer_clock_sel_clear,
  output logic       sec_carry_out
);

  typedef struct packed {
    logic       ce_m;
    logic       ce_s;
    logic       rd_m;
    logic       rd_s;
    logic       wr_m;
    logic       wr_s;
    logic       wr_d;
    logic [3:0] addr_m;
    logic [3:0] addr_s;
    logic [3:0] data_m;
    logic [3:0] data_s;
    logic       bank;
    logic       alarm_en;
    logic       carry_en;
    logic       carry_pend;
    logic       carry_out;
    logic       restart;
    logic       osc_flag;
    logic       osc_d;
    logic       tsel_clr;
    logic       alarm_flag;
    logic       per_flag;
    logic       per_d;
    logic       busy;
    logic [3:0] dout;
    logic       doe;
    logic       irq_n;
  } rtc_dev_state_t;

  localparam rtc_dev_state_t RST_ST = '{
    ce_m: 1'b0, ce_s: 1'b0, rd_m: 1'b1, rd_s: 1'b1, wr_m: 1'b1, wr_s: 1'b1, wr_d: 1'b1,
    addr_m: 4'h0, addr_s: 4'h0, data_m: 4'h0, data_s: 4'h0,
    bank: rtc_pkg::BANK_RST, alarm_en: rtc_pkg::ALARM_EN_RST, carry_en: rtc_pkg::CARRY_EN_RST,
    carry_pend: 1'b0, carry_out: 1'b0, restart: 1'b0, osc_flag: 1'b0, osc_d: 1'b0,
    tsel_clr: 1'b0, alarm_flag: 1'b0, per_flag: 1'b0, per_d: 1'b0, busy: 1'b0,
    dout: 4'h0, doe: 1'b0, irq_n: 1'b1
  };

  rtc_dev_state_t st;
  rtc_dev_state_t next_st;
  logic           wr_take;
  logic           wr_one;
  logic           wr_two;
  logic           clr_osc;
  logic           clr_alarm;
  logic           clr_per;
  logic           rd_act;

  // next-state logic for the whole device end
  always_comb begin
    next_st   = st;
    // every bus pin comes from the host end and is treated as asynchronous
    // decode costs two cycles of latency but never sees a metastable stage
    // pin synchronisers; first stages only feed second stages
    next_st.ce_m   = bus.ce;
    next_st.ce_s   = st.ce_m;
    next_st.rd_m   = bus.rd_n;
    next_st.rd_s   = st.rd_m;
    next_st.wr_m   = bus.wr_n;
    next_st.wr_s   = st.wr_m;
    next_st.wr_d   = st.wr_s;
    next_st.addr_m = bus.addr;
    next_st.addr_s = st.addr_m;
    next_st.data_m = bus.data;
    next_st.data_s = st.data_m;

    // write taken at the trailing edge of the strobe, data still held then
    // taking it at the rising edge gives the data a full strobe to settle
    wr_take = st.ce_s & st.wr_s & ~st.wr_d;
    wr_one  = wr_take & (st.addr_s == rtc_pkg::REG_CTRL_ONE);
    wr_two  = wr_take & (st.addr_s == rtc_pkg::REG_CTRL_TWO);

    if (wr_one) begin
      next_st.bank     = st.data_s[rtc_pkg::CR1_BANK_BIT];
      next_st.alarm_en = st.data_s[rtc_pkg::CR1_ALARM_EN_BIT];
      next_st.carry_en = st.data_s[rtc_pkg::CR1_CARRY_EN_BIT];
    end
    // deselect forces carry
    // applied every idle cycle; the host drops ce at the end of each command, which ends any carry hold
    if (!st.ce_s) begin
      next_st.carry_en = 1'b1;
    end

    next_st.restart = wr_one & st.data_s[rtc_pkg::CR1_RESTART_BIT];

    // held carry release
    // a carry in the release cycle and a held one give two pulses, none lost
    next_st.carry_out  = st.carry_en & (st.carry_pend | sec_carry_in);
    next_st.carry_pend = st.carry_en ? (st.carry_pend & sec_carry_in) : (st.carry_pend | sec_carry_in);

    // write-zero clears only; a one or bit 3 does nothing
    clr_osc   = wr_two & ~st.data_s[rtc_pkg::CR2_OSC_BIT];
    clr_alarm = wr_two & ~st.data_s[rtc_pkg::CR2_ALARM_BIT];
    clr_per   = wr_two & ~st.data_s[rtc_pkg::CR2_PERIODIC_BIT] & periodic_level_mode;

    next_st.osc_flag = osc_stopped | (st.osc_flag & ~clr_osc);

    // timer select clear
    // edge only: a crystal that stays stopped clears the select once
    next_st.osc_d    = osc_stopped;
    next_st.tsel_clr = osc_stopped & ~st.osc_d;

    // alarm flag, dropped with enable
    // dropping it with the enable stops a stale match pulling the pin later
    next_st.alarm_flag = next_st.alarm_en & (alarm_match | (st.alarm_flag & ~clr_alarm));

    // pulse mode follows request, level mode latches
    // pulse mode has no memory, so writes there cannot clear it
    next_st.per_d = periodic_req;
    if (periodic_level_mode) begin
      next_st.per_flag = (periodic_req & ~st.per_d) | (st.per_flag & ~clr_per);
    end else begin
      next_st.per_flag = periodic_req;
    end

    // busy tracks counter chain
    // one cycle late, in step with the flags that share the nibble
    next_st.busy = counter_busy;

    // interrupt from next flags
    // built from next values so pin and flags change on one edge
    // enable low releases same edge
    // match already present is seen on the same edge as enable
    next_st.irq_n = ~((next_st.alarm_en & next_st.alarm_flag) | next_st.per_flag);

    // read drive while selected and read strobe low
    // limitation: data appears three cycles into the strobe; host strobe is longer
    rd_act      = st.ce_s & ~st.rd_s;
    next_st.doe = rd_act;
    if (rd_act && st.addr_s == rtc_pkg::REG_CTRL_TWO) begin
      next_st.dout = {st.busy, st.per_flag, st.alarm_flag, st.osc_flag};
    end else begin
      next_st.dout = 4'h0;
    end
  end

  // single state register
  // asynchronous reset loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  // no combinational path from pins to outputs
  assign bus.dev_data_o        = st.dout;
  assign bus.dev_data_oe       = st.doe;
  assign bus.interrupt_out_n   = st.irq_n;
  assign bank_sel              = st.bank;
  assign alarm_irq_enable      = st.alarm_en;
  assign seconds_carry_enable  = st.carry_en;
  assign timer_restart_reset   = st.restart;
  assign timer_clock_sel_clear = st.tsel_clr;
  assign sec_carry_out         = st.carry_out;

endmodule

/* hdl/rtc_host_ctrl.sv */
// Purpose: host end that runs nibble bus cycles on apb commands
// Assumes: one command in flight; commands while busy are dropped
// Notes:   strobe is long enough for the device synchroniser round trip
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module rtc_host_ctrl (
  // clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt
  output logic             irq,
  // nibble bus
  rtc_nib_if.host          bus
);

  typedef struct packed {
    rtc_pkg::rtc_host_state_t state;
    logic [4:0]  cnt;
    logic [3:0]  addr;
    logic [3:0]  wdata;
    logic        is_wr;
    logic [3:0]  rdata;
    logic        intn_m;
    logic        intn_s;
    logic        intn_d;
    logic [3:0]  d_m;
    logic [3:0]  d_s;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        ce;
    logic        rd_n;
    logic        wr_n;
    logic        doe;
    logic [31:0] prdata;
    logic        irq;
  } rtc_host_st_t;

  localparam rtc_host_st_t RST_ST = '{
    state: rtc_pkg::RTC_H_IDLE, cnt: 5'h00, addr: 4'h0, wdata: 4'h0, is_wr: 1'b0, rdata: 4'h0,
    intn_m: 1'b1, intn_s: 1'b1, intn_d: 1'b1, d_m: 4'h0, d_s: 4'h0, irq_stat: 2'h0,
    irq_mask: 2'h0, ce: 1'b0, rd_n: 1'b1, wr_n: 1'b1, doe: 1'b0, prdata: 32'h0, irq: 1'b0
  };

  rtc_host_st_t st;
  rtc_host_st_t next_st;
  logic         ap_wr;
  logic [1:0]   ev;
  logic [1:0]   w1c;

  // next-state logic of the host end
  always_comb begin
    next_st = st;
    ev      = 2'h0;
    w1c     = 2'h0;
    // synchronisers for device-driven pins
    next_st.intn_m = bus.interrupt_out_n;
    next_st.intn_s = st.intn_m;
    next_st.intn_d = st.intn_s;
    next_st.d_m    = bus.data;
    next_st.d_s    = st.d_m;
    ap_wr          = psel & penable & pwrite;

    // read data captured in setup so access phase answers at once
    if (psel && !penable) begin
      next_st.prdata = 32'h0;
      unique case (paddr)
        rtc_pkg::HOST_CMD_OFS: begin
          next_st.prdata[rtc_pkg::CMD_ADDR_LSB +: 4] = st.addr;
          next_st.prdata[rtc_pkg::CMD_WRITE_BIT]     = st.is_wr;
          next_st.prdata[rtc_pkg::CMD_DATA_LSB +: 4] = st.wdata;
        end
        rtc_pkg::HOST_STAT_OFS: begin
          next_st.prdata[rtc_pkg::STAT_BUSY_BIT]       = (st.state != rtc_pkg::RTC_H_IDLE);
          next_st.prdata[rtc_pkg::STAT_RDATA_LSB +: 4] = st.rdata;
        end
        rtc_pkg::HOST_IRQ_STAT_OFS: next_st.prdata[1:0] = st.irq_stat;
        rtc_pkg::HOST_IRQ_MASK_OFS: next_st.prdata[1:0] = st.irq_mask;
        default:                    next_st.prdata = 32'h0;
      endcase
    end

    if (ap_wr && paddr == rtc_pkg::HOST_IRQ_MASK_OFS) begin
      next_st.irq_mask = pwdata[1:0];
    end
    if (ap_wr && paddr == rtc_pkg::HOST_IRQ_STAT_OFS) begin
      w1c = pwdata[1:0];
    end

    // bus cycle sequencer
    unique case (st.state)
      rtc_pkg::RTC_H_IDLE: begin
        // new command only when idle
        if (ap_wr && paddr == rtc_pkg::HOST_CMD_OFS) begin
          next_st.addr  = pwdata[rtc_pkg::CMD_ADDR_LSB +: 4];
          next_st.is_wr = pwdata[rtc_pkg::CMD_WRITE_BIT];
          next_st.wdata = pwdata[rtc_pkg::CMD_DATA_LSB +: 4];
          next_st.ce    = 1'b1;
          next_st.cnt   = rtc_pkg::CE_SETUP_CNT - 5'h01;
          next_st.state = rtc_pkg::RTC_H_SETUP;
        end
      end
      rtc_pkg::RTC_H_SETUP: begin
        if (st.cnt == 5'h00) begin
          next_st.rd_n  = st.is_wr;
          next_st.wr_n  = ~st.is_wr;
          next_st.doe   = st.is_wr;
          next_st.cnt   = rtc_pkg::STROBE_CNT - 5'h01;
          next_st.state = rtc_pkg::RTC_H_STROBE;
        end else begin
          next_st.cnt = st.cnt - 5'h01;
        end
      end
      rtc_pkg::RTC_H_STROBE: begin
        if (st.cnt == 5'h00) begin
          if (!st.is_wr) begin
            next_st.rdata = st.d_s;
          end
          next_st.rd_n  = 1'b1;
          next_st.wr_n  = 1'b1;
          next_st.cnt   = rtc_pkg::CE_HOLD_CNT - 5'h01;
          next_st.state = rtc_pkg::RTC_H_HOLD;
        end else begin
          next_st.cnt = st.cnt - 5'h01;
        end
      end
      rtc_pkg::RTC_H_HOLD: begin
        // data held past strobe so the device samples a stable nibble
        if (st.cnt == 5'h00) begin
          next_st.ce    = 1'b0;
          next_st.doe   = 1'b0;
          ev[rtc_pkg::IRQ_DONE_BIT] = 1'b1;
          next_st.state = rtc_pkg::RTC_H_IDLE;
        end else begin
          next_st.cnt = st.cnt - 5'h01;
        end
      end
    endcase

    // device interrupt falling edge; set wins over clear
    ev[rtc_pkg::IRQ_DEV_BIT] = st.intn_d & ~st.intn_s;
    next_st.irq_stat = ev | (st.irq_stat & ~w1c);
    next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign prdata           = st.prdata;
  assign pready           = 1'b1;
  assign pslverr          = 1'b0;
  assign irq              = st.irq;
  assign bus.ce           = st.ce;
  assign bus.rd_n         = st.rd_n;
  assign bus.wr_n         = st.wr_n;
  assign bus.addr         = st.addr;
  assign bus.host_data_o  = st.wdata;
  assign bus.host_data_oe = st.doe;

endmodule

/* test/rtc_nib_checker.sv */
// Purpose: protocol checks on the nibble bus joining host and device ends
// Assumes: one clock domain, reset active low
// Notes:   watches only the wires of the nibble bus
`timescale 1ns/1ps
module rtc_nib_checker (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // nibble bus
  input wire logic       ce,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic [3:0] addr,
  input wire logic [3:0] host_data_o,
  input wire logic       host_data_oe,
  input wire logic [3:0] dev_data_o,
  input wire logic       dev_data_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // steps of one bus cycle
  sequence s_rd_start;
    ce && $fell(rd_n) && addr == rtc_pkg::REG_CTRL_TWO;
  endsequence
  sequence s_wr_strobe;
    !wr_n [*8] ##1 wr_n;
  endsequence

  a_cr1_read_zero:
    assert property (dev_data_oe && addr == rtc_pkg::REG_CTRL_ONE |-> dev_data_o == 4'h0)
      else $error("control one read not zero");
  a_unmapped_read_zero:
    assert property (dev_data_oe && addr != rtc_pkg::REG_CTRL_TWO |-> dev_data_o == 4'h0)
      else $error("unassigned read not zero");
  a_read_answer_due:
    assert property (s_rd_start |-> ##[2:4] dev_data_oe) else $error("status read not answered");
  a_read_release_due:
    assert property ($rose(rd_n) |-> ##[2:4] !dev_data_oe) else $error("device kept driving data");
  a_no_bus_fight:
    assert property (!(host_data_oe && dev_data_oe)) else $error("both ends drive data");
  a_host_drive_write:
    assert property (host_data_oe |-> ce && rd_n) else $error("host drives data outside write");
  a_strobe_after_setup:
    assert property ($fell(wr_n) || $fell(rd_n) |-> ce && $past(ce, 10)) else $error("strobe before setup");
  a_write_strobe_width:
    assert property ($fell(wr_n) |-> s_wr_strobe) else $error("write strobe width wrong");
  a_addr_held_cycle:
    assert property (ce && $past(ce) |-> $stable(addr) && $stable(host_data_o)) else $error("address moved in cycle");
endmodule

/* test/rtc_control_status_regs_bench.sv */
// Purpose: self-checking bench of host and device ends joined by the nibble bus
// Assumes: 20 MHz clock, apb master driven here
// Notes:   device side sources are driven directly by the bench
`timescale 1ns/1ps
module rtc_control_status_regs_bench;
  // apb side
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, irq;
  // device side sources and results
  logic        osc_stop = 1'b0, match = 1'b0, per_req = 1'b0, lvl = 1'b0, c_in = 1'b0, busy = 1'b0;
  logic        bank_sel, alarm_en, carry_en, rst_p, tclr_p, c_out;
  logic [3:0]  rnib;
  int          n_fail = 0, check_count = 0, n_rst = 0, n_tclr = 0, n_cout = 0;

  // free running clock
  always #25 pclk = ~pclk;

  rtc_nib_if rtc_nib_if_i ();
  rtc_host_ctrl rtc_host_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .bus(rtc_nib_if_i.host));
  rtc_dev_ctrl rtc_dev_ctrl_i (.pclk(pclk), .presetn(presetn), .bus(rtc_nib_if_i.dev), .osc_stopped(osc_stop),
    .alarm_match(match), .periodic_req(per_req), .periodic_level_mode(lvl), .sec_carry_in(c_in),
    .counter_busy(busy), .bank_sel(bank_sel), .alarm_irq_enable(alarm_en), .seconds_carry_enable(carry_en),
    .timer_restart_reset(rst_p), .timer_clock_sel_clear(tclr_p), .sec_carry_out(c_out));
  rtc_nib_checker rtc_nib_checker_i (.pclk(pclk), .presetn(presetn), .ce(rtc_nib_if_i.ce), .rd_n(rtc_nib_if_i.rd_n),
    .wr_n(rtc_nib_if_i.wr_n), .addr(rtc_nib_if_i.addr), .host_data_o(rtc_nib_if_i.host_data_o),
    .host_data_oe(rtc_nib_if_i.host_data_oe), .dev_data_o(rtc_nib_if_i.dev_data_o),
    .dev_data_oe(rtc_nib_if_i.dev_data_oe));

  // count device pulses; non-blocking so readers never race the count
  always @(posedge pclk) begin
    if (rst_p === 1'b1) n_rst <= n_rst + 1;
    if (tclr_p === 1'b1) n_tclr <= n_tclr + 1;
    if (c_out === 1'b1) n_cout <= n_cout + 1;
  end

  task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task results;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task hang(input string what);
    n_fail++;
    $display("wrong value at %0t: %s timed out", $time, what);
    results();
  endtask

  // one apb transfer, held until pready is seen; read data lands in rdat
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) hang("apb");
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // poll status until the nibble cycle has finished
  task wait_idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, rtc_pkg::HOST_STAT_OFS, 32'h0);
      k++;
    end while (rdat[rtc_pkg::STAT_BUSY_BIT] !== 1'b0 && k < 40);
    if (k >= 40) hang("nibble cycle");
    rnib = rdat[rtc_pkg::STAT_RDATA_LSB +: 4];
  endtask

  task nib(input logic w, input logic [3:0] a, input logic [3:0] d);
    apb(1'b1, rtc_pkg::HOST_CMD_OFS, {20'h0, d, 3'h0, w, a});
    wait_idle();
  endtask

  // unmapped apb place, mask access, masked done event
  task sc_apb_map;
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    apb(1'b0, 12'h010, 32'h0);
    cmp(rdat, 32'h0, "unmapped apb read");
    cmp(32'(pslverr), 32'h0, "no slave error");
    apb(1'b1, rtc_pkg::HOST_IRQ_MASK_OFS, 32'h0000_0002);
    apb(1'b0, rtc_pkg::HOST_IRQ_MASK_OFS, 32'h0);
    cmp(rdat, 32'h2, "mask readback");
    nib(1'b1, 4'hE, 4'h0);
    apb(1'b0, rtc_pkg::HOST_IRQ_STAT_OFS, 32'h0);
    cmp(32'(rdat[rtc_pkg::IRQ_DONE_BIT]), 32'h1, "done event");
    cmp(32'(irq), 32'h0, "masked done");
    apb(1'b1, rtc_pkg::HOST_IRQ_STAT_OFS, 32'h3);
  endtask

  task sc_alarm;
    @(posedge pclk) match <= 1'b1;
    nib(1'b0, 4'hE, 4'h0);
    cmp(32'(rnib), 32'h0, "alarm flag while off");
    cmp(32'(rtc_nib_if_i.interrupt_out_n), 32'h1, "alarm blocked");
    nib(1'b1, 4'hD, 4'hC);
    cmp(32'(alarm_en), 32'h1, "alarm enable");
    cmp(32'(rtc_nib_if_i.interrupt_out_n), 32'h0, "alarm on enable");
    nib(1'b0, 4'hE, 4'h0);
    cmp(32'(rnib), 32'h2, "alarm flag");
    cmp(32'(irq), 32'h1, "device irq");
    apb(1'b1, rtc_pkg::HOST_IRQ_STAT_OFS, 32'h2);
    repeat (2) @(posedge pclk);
    cmp(32'(irq), 32'h0, "irq cleared");
    match <= 1'b0;
    nib(1'b1, 4'hE, 4'h0);
    cmp(32'(rtc_nib_if_i.interrupt_out_n), 32'h1, "alarm flag cleared");
    @(posedge pclk) match <= 1'b1;
    nib(1'b0, 4'hE, 4'h0);
    cmp(32'(rnib), 32'h2, "alarm flag again");
    nib(1'b1, 4'hD, 4'h8);
    cmp(32'(rtc_nib_if_i.interrupt_out_n), 32'h1, "release on disable");
    nib(1'b0, 4'hE, 4'h0);
    cmp(32'(rnib), 32'h0, "flag after disable");
    @(posedge pclk) match <= 1'b0;
  endtask

  // status flags read in bank one, then bank and restart bits
  task sc_flags;
    int t0;
    t0 = n_tclr;
    nib(1'b1, 4'hD, 4'h9);
    cmp(32'(bank_sel), 32'h1, "bank one");
    nib(1'b0, 4'hD, 4'h0);
    cmp(32'(rnib), 32'h0, "control one read");
    @(posedge pclk) osc_stop <= 1'b1;
    @(posedge pclk) osc_stop <= 1'b0;
    busy <= 1'b1;
    per_req <= 1'b1;
    nib(1'b0, 4'hE, 4'h0);
    cmp(32'(rnib), 32'hD, "status flags");
    cmp(32'(n_tclr), 32'(t0 + 1), "timer select clear");
    cmp(32'(rtc_nib_if_i.interrupt_out_n), 32'h0, "periodic low");
    nib(1'b1, 4'hE, 4'hF);
    nib(1'b0, 4'hE, 4'h0);
    cmp(32'(rnib), 32'hD, "ones ignored");
    nib(1'b1, 4'hE, 4'h0);
    nib(1'b0, 4'hE, 4'h0);
    cmp(32'(rnib), 32'hC, "stop flag cleared");
    @(posedge pclk) busy <= 1'b0;
    per_req <= 1'b0;
    lvl <= 1'b1;
    // flag left over from pulse mode is cleared before the level-mode rise
    nib(1'b1, 4'hE, 4'h0);
    nib(1'b0, 4'hE, 4'h0);
    cmp(32'(rnib), 32'h0, "level flag clear first");
    @(posedge pclk) per_req <= 1'b1;
    @(posedge pclk) per_req <= 1'b0;
    nib(1'b0, 4'hE, 4'h0);
    cmp(32'(rnib), 32'h4, "level periodic");
    nib(1'b1, 4'hE, 4'h0);
    nib(1'b0, 4'hE, 4'h0);
    cmp(32'(rnib), 32'h0, "level cleared");
    cmp(32'(rtc_nib_if_i.interrupt_out_n), 32'h1, "released");
    nib(1'b0, 4'h3, 4'h0);
    cmp(32'(rnib), 32'h0, "unassigned read");
    t0 = n_rst;
    nib(1'b1, 4'hD, 4'hA);
    cmp(32'(bank_sel), 32'h0, "bank zero");
    nib(1'b1, 4'hD, 4'h8);
    cmp(32'(n_rst), 32'(t0 + 1), "one restart");
  endtask

  task sc_carry;
    int k;
    int c0;
    c0 = n_cout;
    @(posedge pclk) c_in <= 1'b1;
    @(posedge pclk) c_in <= 1'b0;
    repeat (3) @(posedge pclk);
    cmp(32'(n_cout), 32'(c0 + 1), "carry passed");
    apb(1'b1, rtc_pkg::HOST_CMD_OFS, 32'h0000_001D);
    k = 0;
    while (carry_en !== 1'b0 && k < 60) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 60) hang("carry disable");
    @(posedge pclk) c_in <= 1'b1;
    @(posedge pclk) c_in <= 1'b0;
    cmp(32'(n_cout), 32'(c0 + 1), "carry held");
    wait_idle();
    repeat (4) @(posedge pclk);
    cmp(32'(carry_en), 32'h1, "carry enable forced");
    cmp(32'(n_cout), 32'(c0 + 2), "held carry added");
  endtask

  // reset, scenarios, verdict
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp(32'(carry_en), 32'h1, "carry enable reset");
    cmp(32'(rtc_nib_if_i.interrupt_out_n), 32'h1, "interrupt idle");
    sc_apb_map();
    sc_alarm();
    sc_flags();
    sc_carry();
    results();
  end
endmodule
